/* rtl/thermal_fan_pkg.sv */
// constants, register map and types for the thermal and fan config bank
package thermal_fan_pkg;

    // ---------------------------------------------------------------
    // bus and register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam int          ADDR_W           = 10;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h42;
    localparam logic [7:0]  IDX_IRQ_CLEAR    = 8'h48;
    localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'h49;
    localparam logic [7:0]  IDX_LOCK         = 8'h4A;
    localparam logic [7:0]  IDX_REMOTE_LIMIT = 8'h4B;
    localparam logic [7:0]  IDX_AUX_DATA     = 8'h4C;
    localparam logic [7:0]  IDX_ELAPSED      = 8'h4D;
    localparam logic [7:0]  IDX_ASSERT_LIMIT = 8'h7A;
    localparam logic [7:0]  IDX_PULSES       = 8'h7B;
    localparam logic [7:0]  IDX_CONFIG5      = 8'h7C;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]  RST_ASSERT_LIMIT = 8'h00;
    localparam logic [7:0]  RST_PULSES       = 8'h55;
    localparam logic [7:0]  RST_CONFIG5      = 8'h01;
    localparam logic [7:0]  RST_REMOTE_LIMIT = 8'h80;
    localparam logic [7:0]  RST_ZERO         = 8'h00;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int          BIT_TIMER_FLAG   = 5;
    localparam int          BIT_SIGNED_FMT   = 0;
    localparam int          BIT_OFFSET_SCALE = 1;
    localparam int          BIT_AUX_DIR      = 2;
    localparam int          BIT_AUX_POL      = 3;
    localparam int          BIT_VID_SELECT   = 4;
    localparam int          BIT_REMOTE_ONE   = 5;
    localparam int          BIT_LOCK         = 0;
    localparam int          BIT_AUX_DATA     = 0;
    localparam int          PULSE_FIELD_W    = 2;
    localparam int          FAN_COUNT        = 4;

    // disabled limit codes for each temperature format
    localparam logic [7:0]  LIMIT_OFF_OFFSET = 8'h00;
    localparam logic [7:0]  LIMIT_OFF_SIGNED = 8'h80;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int          CLK_PERIOD_PS    = 4000;
    localparam longint      STEP_TIME_PS     = 64'd22760000000;
    localparam int          STEP_CYCLES      =
        int'(STEP_TIME_PS / CLK_PERIOD_PS);
    localparam logic [7:0]  ELAPSED_MAX      = 8'hFF;

    typedef logic [7:0] byte_t;

endpackage : thermal_fan_pkg

/* rtl/assert_timer_if.sv */
// carrier between the register bank and the assertion timer
interface assert_timer_if;
    logic [7:0] limit;
    logic [7:0] elapsed;
    logic       limit_event;

    modport bank  (output limit, input  elapsed, input  limit_event);
    modport timer (input  limit, output elapsed, output limit_event);
endinterface : assert_timer_if

/* rtl/assert_timer.sv */
// times how long the over-temperature line stays asserted
module assert_timer
    import thermal_fan_pkg::*;
#(
    parameter int STEP_COUNT = STEP_CYCLES
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       asserted,
    assert_timer_if.timer   tif
);

    logic [31:0] prescale;
    logic        asserted_d;
    logic        over_d;

    wire         rise     = asserted & ~asserted_d;
    wire         step     = asserted & (prescale == 32'(STEP_COUNT - 1));
    wire         over     = asserted & ~rise
                          & (tif.elapsed > tif.limit);
    wire         zero_lim = (tif.limit == 8'h00);

    // ---------------------------------------------------------------
    // step prescaler and elapsed count
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else if (step || !asserted) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 32'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tif.elapsed <= 8'h00;
        end else if (rise) begin
            tif.elapsed <= 8'h00;
        end else if (step && tif.elapsed != ELAPSED_MAX) begin
            tif.elapsed <= tif.elapsed + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asserted_d <= 1'b0;
            over_d     <= 1'b0;
        end else begin
            asserted_d <= asserted;
            over_d     <= over;
        end
    end

    // ---------------------------------------------------------------
    // event: first cycle over the limit, or at once for a zero limit
    // ---------------------------------------------------------------
    assign tif.limit_event = (over & ~over_d & ~zero_lim)
                           | (rise & zero_lim);

endmodule : assert_timer

/* rtl/temp_limit_compare.sv */
// compares a temperature against its over-temperature limit
module temp_limit_compare
    import thermal_fan_pkg::*;
(
    input  wire logic       signed_fmt,
    input  wire byte_t      temp,
    input  wire byte_t      limit,
    output logic            limit_off,
    output logic            exceeded
);

    // flipping the sign bit maps twos complement onto offset ordering
    function automatic byte_t ordered(input byte_t v, input logic sgn);
        ordered = sgn ? (v ^ 8'h80) : v;
    endfunction : ordered

    assign limit_off = signed_fmt ? (limit == LIMIT_OFF_SIGNED)
                                  : (limit == LIMIT_OFF_OFFSET);
    assign exceeded  = ordered(temp, signed_fmt)
                    >= ordered(limit, signed_fmt);

endmodule : temp_limit_compare

/* rtl/thermal_fan_config_regs.sv */
// register bank for over-temperature timing, fan pulses and config 5
// Operation
// - Hold an 8-bit assertion time limit in 22.76 ms steps.
// - Set status bit 5 of register 0x42 when assertion time exceeds limit.
// - A zero limit raises the flag as soon as the line asserts.
// - Pulse field codes 0..3 count one to four pulses; two is default.
// - Fan one to four fields sit at bits 1:0, 3:2, 5:4, 7:6.
// - Pulses register resets to 0x55.
// - Config bit 0 picks twos complement or offset-64; values reinterpreted live.
// - Config register 5 resets to 0x01.
// - Config bit 1 selects the scaling of the three offset registers.
// - With aux pin enabled, bit 2 makes it input when clear, output when set.
// - Enabled output aux pin is active low when bit 3 clear, high when set.
// - Bit 4 routes five shared pins to voltage-ID or general purpose.
// - Bit 5 lets remote one limit drive the over-temperature pin.
// - Limit of -64 (offset) or -128 (twos) disables that channel's output.
// - Time how long the over-temperature line stays asserted.
// - Once the lock bit is set, config register 5 ignores writes.
module thermal_fan_config_regs
    import thermal_fan_pkg::*;
#(
    parameter int STEP_COUNT = STEP_CYCLES
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              over_temp_line_in,
    output logic                   over_temp_line_out,
    output logic                   over_temp_line_oe_n,
    input  wire byte_t             remote_one_temp,
    input  wire logic              aux_pin_enable,
    input  wire logic              aux_pin_in,
    output logic                   aux_pin_out,
    output logic                   aux_pin_oe_n,
    output logic [2:0]             first_tach_pulse_count,
    output logic [2:0]             second_tach_pulse_count,
    output logic [2:0]             third_tach_pulse_count,
    output logic [2:0]             fourth_tach_pulse_count,
    output logic                   signed_temp_format,
    output logic                   offset_scale_select,
    output logic                   voltage_id_pin_select
);

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    byte_t assertion_time_limit;
    byte_t tach_pulses_per_rev;
    byte_t format_and_pin_config;
    byte_t remote_one_limit;
    logic  irq_status;
    logic  irq_enable;
    logic  config_lock;
    logic  aux_data;

    assert_timer_if tif ();

    // ---------------------------------------------------------------
    // field views
    // ---------------------------------------------------------------
    logic aux_pin_direction;
    logic aux_pin_polarity;
    logic remote_one_limit_enable;
    logic timer_limit_flag;

    assign aux_pin_direction       = format_and_pin_config[BIT_AUX_DIR];
    assign aux_pin_polarity        = format_and_pin_config[BIT_AUX_POL];
    assign remote_one_limit_enable = format_and_pin_config[BIT_REMOTE_ONE];
    assign signed_temp_format      = format_and_pin_config[BIT_SIGNED_FMT];
    assign offset_scale_select     =
        format_and_pin_config[BIT_OFFSET_SCALE];
    assign voltage_id_pin_select   =
        format_and_pin_config[BIT_VID_SELECT];
    assign timer_limit_flag        = tif.limit_event;

    // ---------------------------------------------------------------
    // pulse count decode
    // ---------------------------------------------------------------
    function automatic logic [2:0] pulses(input byte_t r, input int fan);
        logic [1:0] code;
        code   = r[fan*PULSE_FIELD_W +: PULSE_FIELD_W];
        pulses = {1'b0, code} + 3'd1;
    endfunction : pulses

    assign first_tach_pulse_count  = pulses(tach_pulses_per_rev, 0);
    assign second_tach_pulse_count = pulses(tach_pulses_per_rev, 1);
    assign third_tach_pulse_count  = pulses(tach_pulses_per_rev, 2);
    assign fourth_tach_pulse_count = pulses(tach_pulses_per_rev, 3);

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic [7:0] index;
    logic       word_aligned;
    logic       hit_status;
    logic       hit_clear;
    logic       hit_enable;
    logic       hit_lock;
    logic       hit_remote;
    logic       hit_aux;
    logic       hit_elapsed;
    logic       hit_limit;
    logic       hit_pulses;
    logic       hit_config;
    logic       mapped;
    logic       access;
    logic       wr_en;
    logic       wr_config;

    assign index        = paddr[ADDR_W-1:2];
    assign word_aligned = (paddr[1:0] == 2'b00);
    assign hit_status   = word_aligned && index == IDX_IRQ_STATUS;
    assign hit_clear    = word_aligned && index == IDX_IRQ_CLEAR;
    assign hit_enable   = word_aligned && index == IDX_IRQ_ENABLE;
    assign hit_lock     = word_aligned && index == IDX_LOCK;
    assign hit_remote   = word_aligned && index == IDX_REMOTE_LIMIT;
    assign hit_aux      = word_aligned && index == IDX_AUX_DATA;
    assign hit_elapsed  = word_aligned && index == IDX_ELAPSED;
    assign hit_limit    = word_aligned && index == IDX_ASSERT_LIMIT;
    assign hit_pulses   = word_aligned && index == IDX_PULSES;
    assign hit_config   = word_aligned && index == IDX_CONFIG5;
    assign mapped       = hit_status | hit_clear | hit_enable | hit_lock
                        | hit_remote | hit_aux | hit_elapsed | hit_limit
                        | hit_pulses | hit_config;
    assign access       = psel & penable;
    assign wr_en        = access & pwrite & mapped;
    assign wr_config    = wr_en & hit_config & ~config_lock;

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ---------------------------------------------------------------
    // read mux, captured in the setup cycle
    // ---------------------------------------------------------------
    byte_t read_value;

    assign read_value =
          hit_status  ? 8'(irq_status) << BIT_TIMER_FLAG
        : hit_enable  ? 8'(irq_enable) << BIT_TIMER_FLAG
        : hit_lock    ? 8'(config_lock) << BIT_LOCK
        : hit_remote  ? remote_one_limit
        : hit_aux     ? 8'(aux_pin_in) << BIT_AUX_DATA
        : hit_elapsed ? tif.elapsed
        : hit_limit   ? assertion_time_limit
        : hit_pulses  ? tach_pulses_per_rev
        : hit_config  ? format_and_pin_config
        : RST_ZERO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, read_value};
        end
    end

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            assertion_time_limit <= RST_ASSERT_LIMIT;
        end else if (wr_en && hit_limit) begin
            assertion_time_limit <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tach_pulses_per_rev <= RST_PULSES;
        end else if (wr_en && hit_pulses) begin
            tach_pulses_per_rev <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            format_and_pin_config <= RST_CONFIG5;
        end else if (wr_config) begin
            format_and_pin_config <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_one_limit <= RST_REMOTE_LIMIT;
        end else if (wr_en && hit_remote) begin
            remote_one_limit <= pwdata[7:0];
        end
    end

    // lock is set-only until the next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_lock <= 1'b0;
        end else if (wr_en && hit_lock && pwdata[BIT_LOCK]) begin
            config_lock <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_data   <= 1'b0;
            irq_enable <= 1'b0;
        end else begin
            if (wr_en && hit_aux) begin
                aux_data <= pwdata[BIT_AUX_DATA];
            end
            if (wr_en && hit_enable) begin
                irq_enable <= pwdata[BIT_TIMER_FLAG];
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt status: a new event wins over a same-cycle clear
    // ---------------------------------------------------------------
    logic clear_flag;
    logic next_irq_status;

    assign clear_flag      = wr_en & hit_clear & pwdata[BIT_TIMER_FLAG];
    assign next_irq_status = timer_limit_flag
                           | (irq_status & ~clear_flag);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign irq = irq_status & irq_enable;

    // ---------------------------------------------------------------
    // assertion timer on the active-low over-temperature line
    // ---------------------------------------------------------------
    assign tif.limit = assertion_time_limit;

    assert_timer #(
        .STEP_COUNT (STEP_COUNT)
    ) u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .asserted (~over_temp_line_in),
        .tif      (tif.timer)
    );

    // ---------------------------------------------------------------
    // remote one over-temperature drive
    // ---------------------------------------------------------------
    logic remote_limit_off;
    logic remote_exceeded;
    logic drive_line;

    temp_limit_compare u_cmp (
        .signed_fmt (signed_temp_format),
        .temp       (remote_one_temp),
        .limit      (remote_one_limit),
        .limit_off  (remote_limit_off),
        .exceeded   (remote_exceeded)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_line <= 1'b0;
        end else begin
            drive_line <= remote_one_limit_enable
                        & ~remote_limit_off
                        & remote_exceeded;
        end
    end

    // the line is only ever pulled low; otherwise it is a timer input
    assign over_temp_line_out  = 1'b0;
    assign over_temp_line_oe_n = ~drive_line;

    // ---------------------------------------------------------------
    // auxiliary general-purpose pin
    // ---------------------------------------------------------------
    logic aux_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_level <= 1'b0;
        end else begin
            aux_level <= aux_pin_polarity ? aux_data : ~aux_data;
        end
    end

    assign aux_pin_out  = aux_level;
    assign aux_pin_oe_n = ~(aux_pin_enable & aux_pin_direction);

endmodule : thermal_fan_config_regs

/* dv/thermal_fan_config_regs_props.sv */
// assertion checker for the thermal and fan config bank
module thermal_fan_config_regs_props
    import thermal_fan_pkg::*;
#(
    parameter int STEP_COUNT = STEP_CYCLES
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq,
    input wire logic              over_temp_line_in,
    input wire logic              aux_pin_enable,
    input wire logic              aux_pin_oe_n,
    input wire logic [2:0]        first_tach_pulse_count,
    input wire logic [2:0]        fourth_tach_pulse_count,
    input wire logic              signed_temp_format,
    input wire logic              offset_scale_select,
    input wire logic              voltage_id_pin_select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr;
    logic locked;
    assign wr = psel && penable && pwrite && pready;
    // shadow of the lock bit, set-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) locked <= 1'b0;
        else if (wr && paddr == {IDX_LOCK, 2'b00} && pwdata[0]) locked <= 1'b1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence cfg_wr;
        wr && paddr == {IDX_CONFIG5, 2'b00};
    endsequence
    sequence pulse_wr;
        wr && paddr == {IDX_PULSES, 2'b00};
    endsequence
    sequence clear_quiet;
        wr && paddr == {IDX_IRQ_CLEAR, 2'b00} && pwdata[BIT_TIMER_FLAG]
            && over_temp_line_in && $past(over_temp_line_in)
            && $past(over_temp_line_in, 2);
    endsequence
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    misaligned_err_a: assert property (psel && penable && paddr[1:0] != 2'b00
        |-> pslverr) else $error("misaligned access without error");
    fan_one_a: assert property (pulse_wr |=> first_tach_pulse_count ==
        {1'b0, $past(pwdata[1:0])} + 3'd1) else $error("fan one count wrong");
    fan_four_a: assert property (pulse_wr |=> fourth_tach_pulse_count ==
        {1'b0, $past(pwdata[7:6])} + 3'd1) else $error("fan four count wrong");
    cfg_update_a: assert property (cfg_wr ##0 !locked |=>
        {signed_temp_format, offset_scale_select, voltage_id_pin_select} ==
        {$past(pwdata[0]), $past(pwdata[1]), $past(pwdata[4])})
        else $error("config bits not taken");
    cfg_locked_a: assert property (cfg_wr ##0 locked |=>
        $stable(signed_temp_format) && $stable(voltage_id_pin_select))
        else $error("locked config changed");
    aux_off_a: assert property (!aux_pin_enable |-> aux_pin_oe_n)
        else $error("aux pin driven while disabled");
    irq_clear_a: assert property (clear_quiet |=> !irq)
        else $error("interrupt not cleared");
endmodule : thermal_fan_config_regs_props

bind thermal_fan_config_regs thermal_fan_config_regs_props #(
    .STEP_COUNT(STEP_COUNT)) props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .over_temp_line_in(over_temp_line_in), .aux_pin_enable(aux_pin_enable),
    .aux_pin_oe_n(aux_pin_oe_n),
    .first_tach_pulse_count(first_tach_pulse_count),
    .fourth_tach_pulse_count(fourth_tach_pulse_count),
    .signed_temp_format(signed_temp_format),
    .offset_scale_select(offset_scale_select),
    .voltage_id_pin_select(voltage_id_pin_select));

/* dv/over_temp_source.sv */
// far-side model of the shared open-drain over-temperature line
module over_temp_source (
    input  wire logic assert_req,
    input  wire logic oe_n,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;
    // pulled up; low when either party pulls it down
    assign line = ~(assert_req | ~oe_n);
endmodule : over_temp_source

/* dv/thermal_fan_config_regs_bench.sv */
// self-checking bench for the thermal and fan config bank
module thermal_fan_config_regs_bench;
    import thermal_fan_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEPS = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, line, ot_out, ot_oe_n, ot_req = 0, err;
    logic aux_en = 0, aux_in = 0, aux_out, aux_oe_n;
    logic [2:0] cnt [4];
    logic sfmt, oscale, vidsel;
    byte_t temp = 8'h00;
    int failures = 0, checks = 0;
    always #2 pclk = ~pclk;
    over_temp_source over_temp_source_inst (.assert_req(ot_req),
        .oe_n(ot_oe_n), .line(line));
    thermal_fan_config_regs #(.STEP_COUNT(STEPS)) thermal_fan_config_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .over_temp_line_in(line), .over_temp_line_out(ot_out),
        .over_temp_line_oe_n(ot_oe_n), .remote_one_temp(temp),
        .aux_pin_enable(aux_en), .aux_pin_in(aux_in), .aux_pin_out(aux_out),
        .aux_pin_oe_n(aux_oe_n), .first_tach_pulse_count(cnt[0]),
        .second_tach_pulse_count(cnt[1]), .third_tach_pulse_count(cnt[2]),
        .fourth_tach_pulse_count(cnt[3]), .signed_temp_format(sfmt),
        .offset_scale_select(oscale), .voltage_id_pin_select(vidsel));
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] d, input logic [1:0] lo = 2'b00);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, lo};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle
    task automatic wait_irq(input int n);
        repeat (n) begin
            settle(1);
            if (irq === 1'b1) return;
        end
        check("irq timeout", irq, 1);
        tally_and_finish();
    endtask : wait_irq
    task automatic s_reset();
        apb(0, IDX_ASSERT_LIMIT, 0);
        check("limit reset", rd, 32'h00);
        apb(0, IDX_PULSES, 0);
        check("pulses reset", rd, 32'h55);
        apb(0, IDX_CONFIG5, 0);
        check("config reset", rd, 32'h01);
        check("format reset", sfmt, 1);
        for (int f = 0; f < 4; f++) check("count reset", cnt[f], 2);
        apb(0, 8'h00, 0);
        check("unmapped error", err, 1);
        apb(0, IDX_PULSES, 0, 2'b10);
        check("misaligned error", err, 1);
    endtask : s_reset
    task automatic s_pulses();
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            v = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
            apb(1, IDX_PULSES, {24'h0, v});
            settle(1);
            for (int f = 0; f < 4; f++)
                check("pulse count", cnt[f], 3'(v[2*f+:2]) + 3'd1);
            apb(0, IDX_PULSES, 0);
            check("pulse readback", rd, {24'h0, v});
        end
    endtask : s_pulses
    task automatic s_config();
        aux_en <= 1'b1;
        aux_in <= 1'b1;
        apb(1, IDX_CONFIG5, 32'h1E);
        settle(1);
        check("format bits", {sfmt, oscale, vidsel}, 3'b011);
        check("aux output", aux_oe_n, 0);
        apb(1, IDX_AUX_DATA, 32'h1);
        settle(1);
        check("aux high", aux_out, 1);
        apb(1, IDX_CONFIG5, 32'h16);
        settle(1);
        check("aux low", aux_out, 0);
        apb(1, IDX_CONFIG5, 32'h12);
        settle(1);
        check("aux input", aux_oe_n, 1);
        apb(0, IDX_AUX_DATA, 0);
        check("aux pin read", rd[0], 1);
    endtask : s_config
    task automatic s_zero_limit();
        apb(1, IDX_IRQ_ENABLE, 32'h20);
        @(posedge pclk);
        ot_req <= 1'b1;
        wait_irq(1);
        apb(0, IDX_IRQ_STATUS, 0);
        check("flag set", rd[BIT_TIMER_FLAG], 1);
        ot_req <= 1'b0;
        apb(1, IDX_IRQ_CLEAR, 32'h20);
        settle(1);
        check("flag cleared", irq, 0);
    endtask : s_zero_limit
    task automatic s_timed_limit();
        apb(1, IDX_ASSERT_LIMIT, 32'h02);
        @(posedge pclk);
        ot_req <= 1'b1;
        repeat (2 * STEPS + 1) @(posedge pclk);
        ot_req <= 1'b0;
        settle(2);
        check("equal not exceeded", irq, 0);
        apb(0, IDX_ELAPSED, 0);
        check("elapsed reading", rd, 32'h02);
        @(posedge pclk);
        ot_req <= 1'b1;
        settle(3 * STEPS);
        check("early flag", irq, 0);
        wait_irq(1);
        ot_req <= 1'b0;
        apb(1, IDX_IRQ_CLEAR, 32'h20);
        @(posedge pclk);
        ot_req <= 1'b1;
        settle(2);
        check("restart event", irq, 0);
        ot_req <= 1'b0;
    endtask : s_timed_limit
    task automatic s_drive();
        apb(1, IDX_CONFIG5, 32'h21);
        temp <= 8'h7F;
        settle(2);
        check("limit off", ot_oe_n, 1);
        apb(1, IDX_REMOTE_LIMIT, 32'h10);
        settle(2);
        check("over temp drive", ot_oe_n, 0);
        check("drive level", ot_out, 0);
        apb(1, IDX_CONFIG5, 32'h01);
        settle(2);
        check("timer input only", ot_oe_n, 1);
        temp <= 8'h00;
    endtask : s_drive
    task automatic s_lock();
        apb(1, IDX_LOCK, 32'h1);
        apb(1, IDX_CONFIG5, 32'h00);
        apb(0, IDX_CONFIG5, 0);
        check("locked config", rd, 32'h01);
    endtask : s_lock
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_pulses();
        s_config();
        s_zero_limit();
        s_timed_limit();
        s_drive();
        s_lock();
        tally_and_finish();
    end
endmodule : thermal_fan_config_regs_bench
